// *** bench/dma_channel_slot_config_tb.sv ***
/*
  Self-checking bench for the channel configuration block.
  Assumes the far-side model stands on the data ports.
*/
module dma_channel_slot_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_cfg_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, slot_start, src_valid, src_ready;
  logic src_from_usb, dst_valid, dst_ready, dst_to_usb, wrap, busy;
  logic stall, order_err;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, src_data, dst_data, rx_count, d;
  logic [3:0] slot_index;
  logic [2:0] ep;
  int bad_count, n_checks;

  dma_channel_slot_config uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .slot_start(slot_start), .slot_index(slot_index), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .src_from_usb(src_from_usb),
    .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
    .dst_to_usb(dst_to_usb), .endpoint_number_select(ep),
    .wrap_buffer_enable(wrap), .channel_busy(busy));

  far_side_model far (.clk(clk), .resetn(resetn), .stall(stall),
    .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
    .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
    .rx_count(rx_count), .order_err(order_err));

  // ----------------------------------------------------------------
  // Clock, checks and register access
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // One codec slot, then wait until the channel and buffer are empty
  task slot(input logic [3:0] idx, input logic [7:0] n);
    logic [7:0] base;
    int k;
    base = rx_count;
    @(posedge clk);
    slot_start <= 1'b1;
    slot_index <= idx;
    @(posedge clk);
    slot_start <= 1'b0;
    #1 check({7'h00, busy}, {7'h00, n != 8'h00});
    k = 0;
    while ((busy || dst_valid) && k < 60)
    begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 60)
    begin
      bad_count++;
      results();
    end
    else
      check(rx_count - base, n);
  endtask

  // Hang guard: ends the run as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {reg_wr, reg_rd, slot_start, stall} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    slot_index = 4'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_CTL, d);
    check(d, 8'h00);
    rd(ADDR_SLOT_LOW, d);
    check(d, 8'h00);
    rd(ADDR_SLOT_HIGH, d);
    check(d, 8'h00);
    check({wrap, src_from_usb, dst_to_usb, ep}, 8'h10);
    $display("test reset values done");
    // Reserved bits stay zero; fields reach the outputs
    wr(ADDR_CTL, 8'h7f);
    rd(ADDR_CTL, d);
    check(d, 8'h4f);
    check({wrap, src_from_usb, dst_to_usb, ep}, 8'h2f);
    wr(ADDR_CTL, 8'h01);
    check({wrap, src_from_usb, dst_to_usb, ep}, 8'h11);
    // Unmapped place: writes lost, reads zero
    wr(16'hfff8, 8'hff);
    rd(16'hfff8, d);
    check(d, 8'h00);
    rd(ADDR_CTL, d);
    check(d, 8'h01);
    wr(ADDR_SLOT_LOW, 8'h04);
    wr(ADDR_SLOT_HIGH, 8'hc1);
    rd(ADDR_SLOT_LOW, d);
    check(d, 8'h04);
    rd(ADDR_SLOT_HIGH, d);
    check(d, 8'hc1);
    $display("test register map done");
    // Masked-in slot while run bit is clear stays idle
    slot(4'h8, 8'h00);
    $display("test run disabled done");
    // Every byte count, both directions, stalled sink on the last
    for (int b = 0; b < 4; b++)
    begin
      stall <= (b == 3);
      // Run bit goes last; wrap stays off; endpoint 1, never 0
      wr(ADDR_CTL, 8'h01);
      wr(ADDR_SLOT_HIGH, {b[1:0], 6'h01});
      wr(ADDR_CTL, b[0] ? 8'h81 : 8'h89);
      check({src_from_usb, dst_to_usb}, b[0] ? 8'h02 : 8'h01);
      slot(4'h8, 8'(b + 1));
      slot(4'h2, 8'(b + 1));
      slot(4'h3, 8'h00);
      slot(4'he, 8'h00);
      $display("test byte count %0d done", b + 1);
    end
    check({7'h00, order_err}, 8'h00);
    // Reset in mid-run with the channel enabled: all clears again
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_CTL, d);
    check(d, 8'h00);
    rd(ADDR_SLOT_HIGH, d);
    check(d, 8'h00);
    check({wrap, src_from_usb, dst_to_usb, ep}, 8'h10);
    slot(4'h8, 8'h00);
    $display("test mid-run reset done");
    results();
  end
endmodule

// *** bench/far_side_model.sv ***
/*
  Far side of the channel: byte source and byte sink.
  Assumes the same clock as the channel; the sink may stall.
*/
module far_side_model
(
  input wire logic clk,            // System clock
  input wire logic resetn,         // Async reset, low
  input wire logic stall,          // Sink ready on alternate cycles
  output logic src_valid,          // Source always offers a byte
  output logic [7:0] src_data,     // Rising byte sequence
  input wire logic src_ready,      // Byte taken
  input wire logic dst_valid,      // Sink byte valid
  input wire logic [7:0] dst_data, // Sink byte
  output logic dst_ready,          // Sink accepts
  output logic [7:0] rx_count,     // Bytes received so far
  output logic order_err           // Byte out of sequence
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase_r;

  assign src_valid = resetn;
  assign dst_ready = !stall || phase_r;

  // Source counts up; sink expects the same sequence, so any loss shows
  // byte order kept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_r <= 1'b0;
      src_data <= 8'h00;
      rx_count <= 8'h00;
      order_err <= 1'b0;
    end
    else
    begin
      phase_r <= !phase_r;
      if (src_valid && src_ready)
        src_data <= src_data + 8'h01;
      if (dst_valid && dst_ready)
      begin
        if (dst_data !== rx_count)
          order_err <= 1'b1;
        rx_count <= rx_count + 8'h01;
      end
    end
  end
endmodule

// *** verilog/byte_buffer_if.sv ***
/*
  Handshake bundle between the channel and its two-entry byte buffer.
  Assumes both ends run on the same clock.
*/
interface byte_buffer_if #(parameter int W = 8);
  logic in_valid;
  logic [W-1:0] in_data;
  logic in_ready;
  logic ready_nxt;
  logic out_valid;
  logic [W-1:0] out_data;
  logic out_ready;

  modport store (input in_valid, in_data, out_ready,
                 output in_ready, ready_nxt, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, ready_nxt, out_valid, out_data);
endinterface

// *** verilog/byte_skid_buffer.sv ***
/*
  Two-entry byte buffer; entry 0 is the output register.
  Assumes the writer only pushes while in_ready is high.
*/
module byte_skid_buffer #(parameter int W = 8)
(
  input wire logic clk,            // System clock
  input wire logic resetn,         // Async reset, active low
  byte_buffer_if.store bb          // Buffer handshake
);
  import dma_cfg_pkg::*;

  localparam logic [1:0] DEPTH = 2'h2;

  logic [W-1:0] e0_r, e0_nxt, e1_r, e1_nxt;
  logic [1:0] count_r, count_nxt;
  logic ready_r, valid_r;
  logic push, pop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    push = bb.in_valid && ready_r;
    pop = valid_r && bb.out_ready;
    e0_nxt = e0_r;
    e1_nxt = e1_r;
    count_nxt = count_r + {1'b0, push} - {1'b0, pop};
    if (pop)
    begin
      if (count_r == DEPTH)
        e0_nxt = e1_r;
      else if (push)
        e0_nxt = bb.in_data;
    end
    else if (push)
    begin
      if (count_r == 2'h0)
        e0_nxt = bb.in_data;
      else
        e1_nxt = bb.in_data;
    end
  end

  // in_ready and out_valid are registered flops; ready_nxt reaches the top unregistered
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      e0_r <= '0;
      e1_r <= '0;
      count_r <= 2'h0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end
    else
    begin
      e0_r <= e0_nxt;
      e1_r <= e1_nxt;
      count_r <= count_nxt;
      ready_r <= (count_nxt != DEPTH);
      valid_r <= (count_nxt != 2'h0);
    end
  end

  assign bb.in_ready = ready_r;
  assign bb.ready_nxt = (count_nxt != DEPTH);
  assign bb.out_valid = valid_r;
  assign bb.out_data = e0_r;

  a_no_overflow: assert property (@(posedge clk) disable iff (!resetn)
    count_r == DEPTH |-> !ready_r) else $error("buffer full but ready");
endmodule

// *** verilog/dma_cfg_pkg.sv ***
/*
  Constants and types shared by the DMA channel configuration block.
  Assumes an 8-bit MCU register port with 16-bit addresses.
*/
package dma_cfg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_SLOT_HIGH = 16'hfff5;
  localparam logic [15:0] ADDR_SLOT_LOW = 16'hfff6;
  localparam logic [15:0] ADDR_CTL = 16'hfff7;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable control bits; bits 5:4 are reserved
  localparam logic [7:0] CTL_WRITE_MASK = 8'hcf;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTL_RUN_BIT = 7;
  localparam int CTL_WRAP_BIT = 6;
  localparam int CTL_DIR_BIT = 3;
  localparam int EP_W = 3;
  localparam int BYTES_PER_SLOT_LSB = 6;
  localparam int BYTES_PER_SLOT_W = 2;
  localparam int MASK_LOW_W = 8;
  localparam int MASK_HIGH_W = 6;
  localparam int MASK_W = 14;
  localparam int SLOT_IDX_W = 4;
  localparam int BYTE_CNT_W = 3;
  localparam logic DIR_IN = 1'b1;

  typedef enum logic [1:0] {st_idle, st_wait_slot, st_move} chan_state_type;
endpackage

// *** verilog/dma_channel_slot_config.sv ***
/*
  One DMA channel's configuration registers plus the slot-driven byte mover
  between an endpoint buffer and the codec port.
  Assumes an MCU register port with one-cycle write and registered read,
  a codec port that pulses slot_start with the slot index, and one clock.
*/
module dma_channel_slot_config
(
  input wire logic clk,                                   // 20 MHz clock
  input wire logic resetn,                                // Async reset, low
  input wire logic [15:0] reg_addr,                       // MCU address
  input wire logic reg_wr,                                // Write strobe
  input wire logic reg_rd,                                // Read strobe
  input wire logic [7:0] reg_wdata,                       // Write data
  output logic [7:0] reg_rdata,                           // Read data, 1 cycle
  input wire logic slot_start,                            // Codec slot pulse
  input wire logic [dma_cfg_pkg::SLOT_IDX_W-1:0] slot_index, // Slot number
  input wire logic src_valid,                             // Source byte valid
  input wire logic [7:0] src_data,                        // Source byte
  output logic src_ready,                                 // Byte taken
  output logic src_from_usb,                              // Source is endpoint
  output logic dst_valid,                                 // Sink byte valid
  output logic [7:0] dst_data,                            // Sink byte
  input wire logic dst_ready,                             // Sink accepts
  output logic dst_to_usb,                                // Sink is endpoint
  output logic [dma_cfg_pkg::EP_W-1:0] endpoint_number_select, // Endpoint
  output logic wrap_buffer_enable,                        // To buffer manager
  output logic channel_busy                               // Inside a slot
);
  import dma_cfg_pkg::*;

  logic [7:0] ctl_r, ctl_nxt, slot_low_r, slot_low_nxt;
  logic [7:0] slot_high_r, slot_high_nxt, rdata_r, rdata_nxt;
  logic from_usb_r, from_usb_nxt;
  chan_state_type state_r, state_nxt;
  logic [BYTE_CNT_W-1:0] rem_r, rem_nxt;
  logic src_ready_r, src_ready_nxt, busy_r;
  logic channel_run_enable, endpoint_direction, slot_hit;
  logic [MASK_W-1:0] slot_select_mask;
  logic [BYTES_PER_SLOT_W-1:0] bytes_per_slot;

  byte_buffer_if #(.W(8)) bb ();

  byte_skid_buffer #(.W(8)) u_buf
  (
    .clk(clk),
    .resetn(resetn),
    .bb(bb)
  );

  // ----------------------------------------------------------------
  // Field views of the registers
  // ----------------------------------------------------------------
  assign channel_run_enable = ctl_r[CTL_RUN_BIT];
  assign endpoint_direction = ctl_r[CTL_DIR_BIT];
  assign slot_select_mask = {slot_high_r[MASK_HIGH_W-1:0], slot_low_r};
  assign bytes_per_slot = slot_high_r[BYTES_PER_SLOT_LSB +: BYTES_PER_SLOT_W];
  // only slots with mask bit set
  assign slot_hit = slot_start && (32'(slot_index) < MASK_W)
                    && slot_select_mask[slot_index];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes land next edge; reads return one cycle after the strobe
  always_comb
  begin
    ctl_nxt = ctl_r;
    slot_low_nxt = slot_low_r;
    slot_high_nxt = slot_high_r;
    rdata_nxt = rdata_r;
    if (reg_wr)
    begin
      if (reg_addr == ADDR_CTL)
        ctl_nxt = reg_wdata & CTL_WRITE_MASK;
      else if (reg_addr == ADDR_SLOT_LOW)
        slot_low_nxt = reg_wdata;
      else if (reg_addr == ADDR_SLOT_HIGH)
        slot_high_nxt = reg_wdata;
    end
    if (reg_rd)
    begin
      if (reg_addr == ADDR_CTL)
        rdata_nxt = ctl_r;
      else if (reg_addr == ADDR_SLOT_LOW)
        rdata_nxt = slot_low_r;
      else if (reg_addr == ADDR_SLOT_HIGH)
        rdata_nxt = slot_high_r;
      else
        rdata_nxt = REG_RESET; // Unmapped reads as zero
    end
    from_usb_nxt = (ctl_nxt[CTL_DIR_BIT] != DIR_IN);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_r <= REG_RESET;
      slot_low_r <= REG_RESET;
      slot_high_r <= REG_RESET;
      rdata_r <= REG_RESET;
      from_usb_r <= (REG_RESET[CTL_DIR_BIT] != DIR_IN);
    end
    else
    begin
      ctl_r <= ctl_nxt;
      slot_low_r <= slot_low_nxt;
      slot_high_r <= slot_high_nxt;
      rdata_r <= rdata_nxt;
      from_usb_r <= from_usb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Slot sequencer
  // ----------------------------------------------------------------
  // Dropping run-enable mid-slot abandons the rest of that slot's bytes
  always_comb
  begin
    state_nxt = state_r;
    rem_nxt = rem_r;
    case (state_r)
      st_idle:
      begin
        if (channel_run_enable)
          state_nxt = st_wait_slot;
      end
      st_wait_slot:
      begin
        if (!channel_run_enable)
          state_nxt = st_idle;
        else if (slot_hit)
        begin
          rem_nxt = BYTE_CNT_W'(bytes_per_slot) + BYTE_CNT_W'(1);
          state_nxt = st_move;
        end
      end
      st_move:
      begin
        if (!channel_run_enable)
          state_nxt = st_idle;
        else if (bb.in_valid)
        begin
          rem_nxt = rem_r - BYTE_CNT_W'(1);
          if (rem_nxt == '0)
            state_nxt = st_wait_slot;
        end
      end
      default:
        state_nxt = st_idle;
    endcase
    // Ready is a flop, so it looks ahead at next state and buffer room
    src_ready_nxt = (state_nxt == st_move) && (rem_nxt != '0) && bb.ready_nxt;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= st_idle;
      rem_r <= '0;
      src_ready_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rem_r <= rem_nxt;
      src_ready_r <= src_ready_nxt;
      busy_r <= (state_nxt == st_move);
    end
  end

  // ----------------------------------------------------------------
  // Data path through the buffer
  // ----------------------------------------------------------------
  // bytes flow source to sink via buffer
  assign bb.in_valid = src_valid && src_ready_r && (state_r == st_move);
  assign bb.in_data = src_data;
  assign bb.out_ready = dst_ready;

  assign reg_rdata = rdata_r;
  assign src_ready = src_ready_r;
  // IN: codec to endpoint; OUT: endpoint to codec
  assign dst_to_usb = (endpoint_direction == DIR_IN);
  assign src_from_usb = from_usb_r;
  assign dst_valid = bb.out_valid;
  assign dst_data = bb.out_data;
  assign endpoint_number_select = ctl_r[EP_W-1:0];
  // per-channel wrap bit, shared with buffer manager
  assign wrap_buffer_enable = ctl_r[CTL_WRAP_BIT];
  assign channel_busy = busy_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_idle_when_off: assert property (@(posedge clk) disable iff (!resetn)
    !channel_run_enable |=> !src_ready && !channel_busy)
    else $error("channel active while disabled");
  a_wrap_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == ADDR_CTL
    |=> wrap_buffer_enable == $past(reg_wdata[CTL_WRAP_BIT]))
    else $error("wrap bit did not follow write");
  a_dir_route: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == ADDR_CTL
    |=> dst_to_usb == $past(reg_wdata[CTL_DIR_BIT]) && src_from_usb != dst_to_usb)
    else $error("direction routing broken");
  a_ep_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == ADDR_CTL
    |=> endpoint_number_select == $past(reg_wdata[EP_W-1:0]))
    else $error("endpoint field wrong");
  a_slot_miss: assert property (@(posedge clk) disable iff (!resetn)
    state_r == st_wait_slot && channel_run_enable && !slot_hit |=> !channel_busy)
    else $error("moved in unmasked slot");
  a_mask_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && !reg_wr && reg_addr == ADDR_SLOT_HIGH
    |=> reg_rdata[MASK_HIGH_W-1:0] == slot_select_mask[MASK_W-1:MASK_LOW_W])
    else $error("high mask readback wrong");
  a_byte_count: assert property (@(posedge clk) disable iff (!resetn)
    state_r == st_wait_slot && channel_run_enable && slot_hit
    |=> rem_r == BYTE_CNT_W'($past(bytes_per_slot)) + 3'h1)
    else $error("bytes per slot wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    ##1 ctl_r[5:4] == 2'h0) else $error("reserved bits set");
  a_push_in_slot: assert property (@(posedge clk) disable iff (!resetn)
    src_ready |-> channel_busy && rem_r != '0) else $error("ready outside slot");
  a_push_room: assert property (@(posedge clk) disable iff (!resetn)
    bb.in_valid |-> bb.in_ready) else $error("byte offered to full buffer");
endmodule
